//--- common/gtm_regs.vh
`ifndef GTM_REGS_VH
`define GTM_REGS_VH

// *****************************************************************
// configuration register encodings
// *****************************************************************
`define GTM_CFG_W           3
`define GTM_CFG_32_TIMER    3'h0
`define GTM_CFG_32_RTC      3'h1
`define GTM_CFG_16_SPLIT    3'h4
`define GTM_CFG_RESET       3'h0

// *****************************************************************
// mode field encodings
// *****************************************************************
`define GTM_MODE_W          2
`define GTM_MODE_ONESHOT    2'h1
`define GTM_MODE_PERIODIC   2'h2
`define GTM_MODE_RESET      2'h0

// *****************************************************************
// reset and special values
// *****************************************************************
`define GTM_CNT16_RESET     16'hFFFF
`define GTM_ZERO16          16'h0000
`define GTM_ONE16           16'h0001
`define GTM_PRESCALE_RESET  8'h00
`define GTM_ZERO32          32'h00000000
`define GTM_ONE32           32'h00000001
`define GTM_RTC_START       32'h00000001
`define GTM_MATCH_RESET     32'hFFFFFFFF

// *****************************************************************
// real-time clock divider
// *****************************************************************
`define GTM_RTC_SRC_HZ      32768
`define GTM_RTC_OUT_HZ      1
`define GTM_RTC_DIV_W       15

`endif

//--- hw/gtm_rtc_divider.v
`timescale 1ns/10ps
`include "gtm_regs.vh"

module gtm_rtc_divider #(
    parameter integer DIVIDE = `GTM_RTC_SRC_HZ / `GTM_RTC_OUT_HZ,
    parameter integer DIV_W  = `GTM_RTC_DIV_W
) (
    input  wire clk,
    input  wire rst_n,
    input  wire run,
    input  wire ref_clk_in,
    output reg  tick
);

    localparam [DIV_W-1:0] LAST = DIVIDE[DIV_W-1:0] - 1'b1;

    reg             ref_prev;
    reg [DIV_W-1:0] edge_count;
    wire            ref_rise;

    assign ref_rise = ref_clk_in & ~ref_prev;

    // *************************************************************
    // one tick per DIVIDE reference edges
    // *************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            ref_prev   <= 1'b0;
            edge_count <= {DIV_W{1'b0}};
            tick       <= 1'b0;
        end else begin
            ref_prev <= ref_clk_in;
            tick     <= 1'b0;
            if (!run) begin
                edge_count <= {DIV_W{1'b0}};
            end else if (ref_rise) begin // [R17]
                if (edge_count == LAST) begin
                    edge_count <= {DIV_W{1'b0}};
                    tick       <= 1'b1;
                end else begin
                    edge_count <= edge_count + {{(DIV_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

//--- hw/gtm_timer.v
// Functional notes
// [R1] two 16-bit counters, separate or joined into one 32-bit
// [R2] after reset idle; counts and loads hold 0xFFFF
// [R3] after reset both prescale registers hold 0x00
// [R4] configuration 0 selects 32-bit timer, 1 the 32-bit clock
// [R5] configuration 0x4 selects 16-bit mode with separate counters
// [R6] 32-bit modes act as one timer; 16-bit halves run independently
// [R7] 32-bit load write: low half to A, high half to B
// [R8] 32-bit read returns B count high, A count low
// [R9] in 32-bit timer mode only the A mode field matters
// [R10] enable counts down; after zero reload from joined load
// [R11] one-shot stops and clears A enable; periodic keeps counting
// [R12] zero sets A time-out raw flag until software clears it
// [R13] unmasked time-out also sets the A masked time-out flag
// [R14] load rewrite while running takes effect next cycle
// [R15] stall bit freezes timer during debug halt
// [R16] clock mode counts up from 1; loads via match register
// [R17] 32.768 kHz on even pin divided to 1 Hz drives the count
// [R18] count equal to match rolls over to zero
// [R19] match sets raw and unmasked masked flag; clear clears both
// [R20] clock enable bit set: no freeze in debug halt
// [R21] time-out flag set in the reload cycle
`timescale 1ns/10ps
`include "gtm_regs.vh"

module gtm_timer #(
    parameter integer RTC_DIVIDE = `GTM_RTC_SRC_HZ / `GTM_RTC_OUT_HZ
) (
    input  wire                   clk,
    input  wire                   rst_n,
    // configuration and mode
    input  wire                   cfg_wr,
    input  wire [`GTM_CFG_W-1:0]  cfg_wdata,
    input  wire                   mode_a_wr,
    input  wire [`GTM_MODE_W-1:0] mode_a_wdata,
    input  wire                   mode_b_wr,
    input  wire [`GTM_MODE_W-1:0] mode_b_wdata,
    // control
    input  wire                   ctl_wr,
    input  wire                   ctl_enable_a,
    input  wire                   ctl_enable_b,
    input  wire                   ctl_stall_a,
    input  wire                   ctl_stall_b,
    input  wire                   ctl_realtime_en,
    // loads, prescale, match
    input  wire                   load_a_wr,
    input  wire [31:0]            load_a_wdata,
    input  wire                   load_b_wr,
    input  wire [15:0]            load_b_wdata,
    input  wire                   prescale_a_wr,
    input  wire [7:0]             prescale_a_wdata,
    input  wire                   prescale_b_wr,
    input  wire [7:0]             prescale_b_wdata,
    input  wire                   match_wr,
    input  wire [31:0]            match_wdata,
    // mask and clear
    input  wire                   mask_timeout_a,
    input  wire                   mask_timeout_b,
    input  wire                   mask_realtime_match,
    input  wire                   clear_timeout_a,
    input  wire                   clear_timeout_b,
    input  wire                   clear_realtime_match,
    // system inputs
    input  wire                   debug_halt,
    input  wire                   capture_compare_pin_even,
    // status
    output reg  [`GTM_CFG_W-1:0]  timer_configuration,
    output reg  [`GTM_MODE_W-1:0] counter_a_mode_field,
    output reg  [`GTM_MODE_W-1:0] counter_b_mode_field,
    output reg                    counter_a_enable_bit,
    output reg                    counter_b_enable_bit,
    output reg                    counter_a_debug_stall_bit,
    output reg                    counter_b_debug_stall_bit,
    output reg                    realtime_enable_bit,
    output reg  [15:0]            counter_a_interval_load,
    output reg  [15:0]            counter_b_interval_load,
    output reg  [7:0]             counter_a_prescale,
    output reg  [7:0]             counter_b_prescale,
    output reg  [31:0]            counter_a_match_register,
    output wire [31:0]            counter_a_value,
    output wire [15:0]            counter_b_value,
    output reg                    counter_a_timeout_raw_flag,
    output reg                    counter_b_timeout_raw_flag,
    output reg                    realtime_match_raw_flag,
    output wire                   counter_a_timeout_masked_flag,
    output wire                   counter_b_timeout_masked_flag,
    output wire                   realtime_match_masked_flag
);

    reg  [15:0] count_a;
    reg  [15:0] count_b;
    wire [31:0] count_joined;
    wire [31:0] load_joined;
    wire        mode_32_timer;
    wire        mode_32_rtc;
    wire        mode_16;
    wire        freeze_a;
    wire        freeze_b;
    wire        rtc_tick;
    wire        run_a;
    wire        run_b;
    reg         hw_clear_enable_a;
    reg         hw_clear_enable_b;
    reg         set_timeout_a;
    reg         set_timeout_b;
    reg         set_match;

    // *************************************************************
    // mode decode
    // *************************************************************
    assign mode_32_timer = (timer_configuration == `GTM_CFG_32_TIMER); // [R4]
    assign mode_32_rtc   = (timer_configuration == `GTM_CFG_32_RTC);   // [R4]
    assign mode_16       = (timer_configuration == `GTM_CFG_16_SPLIT); // [R5]

    assign count_joined = {count_b, count_a};
    assign load_joined  = {counter_b_interval_load, counter_a_interval_load};

    // clock enable overrides stall
    assign freeze_a = counter_a_debug_stall_bit & debug_halt
                      & ~(mode_32_rtc & realtime_enable_bit); // [R15] [R20]
    assign freeze_b = counter_b_debug_stall_bit & debug_halt;  // [R15]

    assign run_a = counter_a_enable_bit & ~freeze_a;
    assign run_b = counter_b_enable_bit & ~freeze_b;

    // joined read outside split mode
    assign counter_a_value = mode_16 ? {`GTM_ZERO16, count_a} : count_joined; // [R8]
    assign counter_b_value = count_b;

    assign counter_a_timeout_masked_flag =
        counter_a_timeout_raw_flag & mask_timeout_a; // [R13]
    assign counter_b_timeout_masked_flag =
        counter_b_timeout_raw_flag & mask_timeout_b;
    assign realtime_match_masked_flag =
        realtime_match_raw_flag & mask_realtime_match; // [R19]

    // *************************************************************
    // reference divider
    // *************************************************************
    gtm_rtc_divider #(
        .DIVIDE (RTC_DIVIDE),
        .DIV_W  (`GTM_RTC_DIV_W)
    ) u_rtc_divider (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (mode_32_rtc & counter_a_enable_bit),
        .ref_clk_in (capture_compare_pin_even),
        .tick       (rtc_tick)
    );

    // *************************************************************
    // configuration registers
    // *************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            timer_configuration      <= `GTM_CFG_RESET;
            counter_a_mode_field     <= `GTM_MODE_RESET;
            counter_b_mode_field     <= `GTM_MODE_RESET;
            counter_a_prescale       <= `GTM_PRESCALE_RESET; // [R3]
            counter_b_prescale       <= `GTM_PRESCALE_RESET; // [R3]
            counter_a_match_register <= `GTM_MATCH_RESET;
        end else begin
            if (cfg_wr) begin
                timer_configuration <= cfg_wdata;
            end
            if (mode_a_wr) begin
                counter_a_mode_field <= mode_a_wdata;
            end
            if (mode_b_wr) begin
                counter_b_mode_field <= mode_b_wdata;
            end
            if (prescale_a_wr) begin
                counter_a_prescale <= prescale_a_wdata;
            end
            if (prescale_b_wr) begin
                counter_b_prescale <= prescale_b_wdata;
            end
            if (match_wr) begin
                counter_a_match_register <= match_wdata; // [R16]
            end
        end
    end

    // *************************************************************
    // control; software write beats hw clear
    // *************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            counter_a_enable_bit      <= 1'b0; // [R2]
            counter_b_enable_bit      <= 1'b0;
            counter_a_debug_stall_bit <= 1'b0;
            counter_b_debug_stall_bit <= 1'b0;
            realtime_enable_bit       <= 1'b0;
        end else if (ctl_wr) begin
            counter_a_enable_bit      <= ctl_enable_a;
            counter_b_enable_bit      <= ctl_enable_b;
            counter_a_debug_stall_bit <= ctl_stall_a;
            counter_b_debug_stall_bit <= ctl_stall_b;
            realtime_enable_bit       <= ctl_realtime_en;
        end else begin
            if (hw_clear_enable_a) begin
                counter_a_enable_bit <= 1'b0; // [R11]
            end
            if (hw_clear_enable_b) begin
                counter_b_enable_bit <= 1'b0;
            end
        end
    end

    // *************************************************************
    // event decode per mode
    // *************************************************************
    always @* begin
        hw_clear_enable_a = 1'b0;
        hw_clear_enable_b = 1'b0;
        set_timeout_a     = 1'b0;
        set_timeout_b     = 1'b0;
        set_match         = 1'b0;
        if (mode_32_timer) begin
            if (run_a && count_joined == `GTM_ZERO32) begin
                set_timeout_a     = 1'b1; // [R12] [R21]
                hw_clear_enable_a = (counter_a_mode_field == `GTM_MODE_ONESHOT); // [R9] [R11]
            end
        end else if (mode_32_rtc) begin
            if (run_a && rtc_tick && count_joined == counter_a_match_register) begin
                set_match = 1'b1; // [R19]
            end
        end else if (mode_16) begin
            if (run_a && count_a == `GTM_ZERO16) begin
                set_timeout_a     = 1'b1;
                hw_clear_enable_a = (counter_a_mode_field == `GTM_MODE_ONESHOT);
            end
            if (run_b && count_b == `GTM_ZERO16) begin
                set_timeout_b     = 1'b1;
                hw_clear_enable_b = (counter_b_mode_field == `GTM_MODE_ONESHOT); // [R6]
            end
        end
    end

    // *************************************************************
    // load registers and counters
    // *************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            count_a                 <= `GTM_CNT16_RESET; // [R2]
            count_b                 <= `GTM_CNT16_RESET; // [R2]
            counter_a_interval_load <= `GTM_CNT16_RESET; // [R2]
            counter_b_interval_load <= `GTM_CNT16_RESET; // [R2]
        end else if (cfg_wr && cfg_wdata == `GTM_CFG_32_RTC && !mode_32_rtc) begin
            {count_b, count_a} <= `GTM_RTC_START; // [R16]
        end else if (load_a_wr && !mode_16) begin
            counter_a_interval_load <= load_a_wdata[15:0];  // [R7]
            counter_b_interval_load <= load_a_wdata[31:16]; // [R7]
            if (!mode_32_rtc) begin
                {count_b, count_a} <= load_a_wdata; // [R14]
            end
        end else if (mode_32_timer) begin
            if (run_a) begin
                if (count_joined == `GTM_ZERO32) begin
                    {count_b, count_a} <= load_joined; // [R10]
                end else begin
                    {count_b, count_a} <= count_joined - `GTM_ONE32; // [R10]
                end
            end
        end else if (mode_32_rtc) begin
            if (run_a && rtc_tick) begin // [R17]
                if (count_joined == counter_a_match_register) begin
                    {count_b, count_a} <= `GTM_ZERO32; // [R18]
                end else begin
                    {count_b, count_a} <= count_joined + `GTM_ONE32; // [R16]
                end
            end
        end else if (mode_16) begin
            if (load_a_wr) begin
                counter_a_interval_load <= load_a_wdata[15:0];
                count_a                 <= load_a_wdata[15:0];
            end else if (run_a) begin
                if (count_a == `GTM_ZERO16) begin
                    count_a <= counter_a_interval_load;
                end else begin
                    count_a <= count_a - `GTM_ONE16;
                end
            end
            if (load_b_wr) begin
                counter_b_interval_load <= load_b_wdata;
                count_b                 <= load_b_wdata;
            end else if (run_b) begin // [R1]
                if (count_b == `GTM_ZERO16) begin
                    count_b <= counter_b_interval_load;
                end else begin
                    count_b <= count_b - `GTM_ONE16;
                end
            end
        end
    end

    // *************************************************************
    // sticky flags; set wins
    // *************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            counter_a_timeout_raw_flag <= 1'b0;
            counter_b_timeout_raw_flag <= 1'b0;
            realtime_match_raw_flag    <= 1'b0;
        end else begin
            if (set_timeout_a) begin
                counter_a_timeout_raw_flag <= 1'b1; // [R12]
            end else if (clear_timeout_a) begin
                counter_a_timeout_raw_flag <= 1'b0; // [R12]
            end
            if (set_timeout_b) begin
                counter_b_timeout_raw_flag <= 1'b1;
            end else if (clear_timeout_b) begin
                counter_b_timeout_raw_flag <= 1'b0;
            end
            if (set_match) begin
                realtime_match_raw_flag <= 1'b1; // [R19]
            end else if (clear_realtime_match) begin
                realtime_match_raw_flag <= 1'b0; // [R19]
            end
        end
    end

endmodule

//--- tb/gtm_timer_monitor.sv
`timescale 1ns/10ps
`include "gtm_regs.vh"
module gtm_timer_monitor (
    input wire                   clk,
    input wire                   rst_n,
    input wire                   cfg_wr,
    input wire [`GTM_CFG_W-1:0]  cfg_wdata,
    input wire                   load_a_wr,
    input wire [31:0]            load_a_wdata,
    input wire                   ctl_wr,
    input wire                   debug_halt,
    input wire                   mask_timeout_a,
    input wire                   clear_timeout_a,
    input wire [`GTM_CFG_W-1:0]  timer_configuration,
    input wire [`GTM_MODE_W-1:0] counter_a_mode_field,
    input wire                   counter_a_enable_bit,
    input wire                   counter_a_debug_stall_bit,
    input wire [15:0]            counter_a_interval_load,
    input wire [15:0]            counter_b_interval_load,
    input wire [31:0]            counter_a_value,
    input wire                   counter_a_timeout_raw_flag,
    input wire                   counter_a_timeout_masked_flag,
    input wire                   realtime_match_raw_flag
);
    // ****************
    // shorthand
    // ****************
    wire [31:0] v   = counter_a_value;
    wire [31:0] ld  = {counter_b_interval_load, counter_a_interval_load};
    wire        t32 = timer_configuration == `GTM_CFG_32_TIMER && !cfg_wr;
    wire        frz = counter_a_debug_stall_bit && debug_halt;
    wire        rtc = timer_configuration == `GTM_CFG_32_RTC;
    wire        raw = counter_a_timeout_raw_flag;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence zero_hit;
        t32 && counter_a_enable_bit && v == 32'h0 && !frz && !ctl_wr && !load_a_wr;
    endsequence
    sequence oneshot_hit;
        zero_hit ##0 counter_a_mode_field == `GTM_MODE_ONESHOT;
    endsequence
    sequence periodic_hit;
        zero_hit ##0 counter_a_mode_field != `GTM_MODE_ONESHOT;
    endsequence
    // ****************
    // assertions
    // ****************
    reset_vals_a: assert property ($rose(rst_n) |-> &v && &ld)
        else $error("bad reset values");
    load_split_a: assert property (load_a_wr && !cfg_wr && timer_configuration != 3'h4
        |=> ld == $past(load_a_wdata)) else $error("load split");
    load_take_a: assert property (load_a_wr && t32 |=> v == $past(load_a_wdata))
        else $error("load not taken");
    timeout_set_a: assert property (zero_hit |=> raw && v == $past(ld))
        else $error("no reload at zero");
    oneshot_stop_a: assert property (oneshot_hit |=> !counter_a_enable_bit)
        else $error("one-shot ran on");
    periodic_keep_a: assert property (periodic_hit |=> counter_a_enable_bit)
        else $error("periodic stopped");
    no_spurious_a: assert property (t32 && !raw && v != 32'h0 |=> !raw)
        else $error("spurious time-out");
    flag_hold_a: assert property (raw && !clear_timeout_a |=> raw)
        else $error("flag dropped");
    flag_clear_a: assert property (raw && clear_timeout_a && t32 && v != 32'h0 |=> !raw)
        else $error("flag not cleared");
    masked_a: assert property (counter_a_timeout_masked_flag == (raw && mask_timeout_a))
        else $error("masked flag wrong");
    stall_freeze_a: assert property (t32 && frz && !load_a_wr && !ctl_wr |=> $stable(v))
        else $error("count moved in halt");
    rtc_start_a: assert property (cfg_wr && cfg_wdata == `GTM_CFG_32_RTC && !rtc
        |=> v == `GTM_RTC_START) else $error("clock start not one");
    rtc_step_a: assert property (rtc && !cfg_wr |=> v - $past(v) <= 32'h1 || v == 32'h0)
        else $error("clock step wrong");
    rtc_match_a: assert property ($rose(realtime_match_raw_flag) |-> v == 32'h0)
        else $error("match without roll-over");
endmodule

//--- tb/gtm_ref_osc.sv
`timescale 1ns/10ps
// ****************
// reference clock
// ****************
module gtm_ref_osc #(
    parameter real HALF_NS = 15258.8
) (
    input  wire  run,
    output logic pin
);
    initial pin = 1'h0;
    always begin
        wait (run); // idle low when stopped
        #(HALF_NS) pin = ~pin;
        if (!run) pin = 1'h0;
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
`include "gtm_regs.vh"
bind gtm_timer gtm_timer_monitor u_gtm_timer_monitor (.*);
module tb_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_a_wr, load_b_wr, match_wr, osc_run;
    logic prescale_a_wr, prescale_b_wr, clear_timeout_a, clear_timeout_b, clear_realtime_match;
    logic ctl_enable_a, ctl_enable_b, ctl_stall_a, ctl_stall_b, ctl_realtime_en, debug_halt;
    logic mask_timeout_a, mask_timeout_b, mask_realtime_match;
    logic [2:0] cfg_wdata;
    logic [1:0] mode_a_wdata, mode_b_wdata;
    logic [31:0] load_a_wdata, match_wdata, r;
    logic [15:0] load_b_wdata;
    logic [7:0] prescale_a_wdata, prescale_b_wdata;
    wire capture_compare_pin_even, counter_a_enable_bit, counter_b_enable_bit;
    wire counter_a_debug_stall_bit, counter_b_debug_stall_bit, realtime_enable_bit;
    wire counter_a_timeout_raw_flag, counter_b_timeout_raw_flag, realtime_match_raw_flag;
    wire counter_a_timeout_masked_flag, counter_b_timeout_masked_flag, realtime_match_masked_flag;
    wire [2:0] timer_configuration;
    wire [1:0] counter_a_mode_field, counter_b_mode_field;
    wire [15:0] counter_a_interval_load, counter_b_interval_load, counter_b_value;
    wire [7:0] counter_a_prescale, counter_b_prescale;
    wire [31:0] counter_a_match_register, counter_a_value;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 32'h1287;
    int id_q[$];
    logic [31:0] exp_q[$];
    string names[7] = '{"value","flags","loads","pres","rtc","b","match"};
    gtm_timer #(.RTC_DIVIDE(4)) u_gtm_timer (.*);
    gtm_ref_osc u_gtm_ref_osc (.run(osc_run), .pin(capture_compare_pin_even));
    always #5 clk = ~clk;
    // ****************
    // scoreboard
    // ****************
    function automatic logic [31:0] obs(int id);
        case (id)
            0: return counter_a_value;
            1: return {29'h0, counter_a_enable_bit, counter_a_timeout_masked_flag, counter_a_timeout_raw_flag};
            2: return {counter_b_interval_load, counter_a_interval_load};
            3: return {16'h0, counter_b_prescale, counter_a_prescale};
            4: return {30'h0, realtime_match_masked_flag, realtime_match_raw_flag};
            5: return {30'h0, counter_b_enable_bit, counter_b_timeout_raw_flag};
            default: return counter_a_match_register;
        endcase
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp, int id);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", names[id], exp, seen);
        end
    endtask
    task automatic expect_val(int id, logic [31:0] v);
        id_q.push_back(id);
        exp_q.push_back(v);
    endtask
    always @(negedge clk) begin
        while (id_q.size() > 0) begin
            check(obs(id_q[0]), exp_q[0], id_q[0]);
            void'(id_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    task automatic wait_on(int id, logic [31:0] m, int lim);
        int k;
        k = 0;
        while ((obs(id) & m) !== m && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (k == lim) check(obs(id) & m, m, id);
        @(posedge clk);
    endtask
    task automatic go();
        @(posedge clk);
        {cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_a_wr, load_b_wr, match_wr} <= '0;
        {prescale_a_wr, prescale_b_wr, clear_timeout_a, clear_realtime_match} <= '0;
    endtask
    task automatic end_sim();
        $display("compared %0d bad %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            $display("BAD cycles exp %0d seen %0d", 60000, cyc);
            end_sim();
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        {cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_a_wr, load_b_wr, match_wr, osc_run} = '0;
        {prescale_a_wr, prescale_b_wr, clear_timeout_a, clear_timeout_b, clear_realtime_match} = '0;
        {ctl_enable_a, ctl_enable_b, ctl_stall_a, ctl_stall_b, ctl_realtime_en, debug_halt} = '0;
        {mask_timeout_a, mask_timeout_b, mask_realtime_match} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        expect_val(0, 32'hFFFFFFFF);
        expect_val(2, 32'hFFFFFFFF);
        expect_val(1, 32'h0);
        expect_val(3, 32'h0);
        r = $random(seed);
        @(posedge clk);
        prescale_a_wr <= 1'h1;
        prescale_b_wr <= 1'h1;
        {prescale_b_wdata, prescale_a_wdata} <= r[15:0];
        go();
        expect_val(3, {16'h0, r[15:0]});
        $display("reset done");
        @(posedge clk);
        {cfg_wr, mode_a_wr, mode_b_wr, mask_timeout_a} <= 4'hF;
        cfg_wdata <= `GTM_CFG_32_TIMER;
        mode_a_wdata <= `GTM_MODE_ONESHOT;
        mode_b_wdata <= `GTM_MODE_PERIODIC;
        go();
        r = $random(seed);
        @(posedge clk);
        load_a_wr <= 1'h1;
        load_a_wdata <= r;
        go();
        expect_val(2, r);
        expect_val(0, r);
        @(posedge clk);
        load_a_wr <= 1'h1;
        load_a_wdata <= 32'h5;
        go();
        @(posedge clk);
        {ctl_wr, ctl_enable_a} <= 2'h3;
        go();
        wait_on(1, 32'h1, 20);
        expect_val(1, 32'h3);
        expect_val(0, 32'h5);
        @(posedge clk);
        clear_timeout_a <= 1'h1;
        go();
        expect_val(1, 32'h0);
        $display("one-shot done");
        @(posedge clk);
        {mode_a_wr, mask_timeout_a} <= 2'h2;
        mode_a_wdata <= `GTM_MODE_PERIODIC;
        go();
        @(posedge clk);
        {ctl_wr, ctl_enable_a, ctl_stall_a} <= 3'h7;
        go();
        wait_on(1, 32'h1, 20);
        expect_val(1, 32'h5);
        load_a_wr <= 1'h1;
        load_a_wdata <= 32'h1000;
        debug_halt <= 1'h1;
        go();
        expect_val(0, 32'h1000);
        repeat (3) @(posedge clk);
        expect_val(0, 32'h1000);
        debug_halt <= 1'h0;
        @(posedge clk);
        expect_val(0, 32'hFFF);
        ctl_wr <= 1'h1;
        {ctl_enable_a, ctl_stall_a} <= 2'h0;
        go();
        $display("periodic done");
        @(posedge clk);
        {cfg_wr, mode_a_wr} <= 2'h3;
        cfg_wdata <= `GTM_CFG_16_SPLIT;
        mode_a_wdata <= `GTM_MODE_ONESHOT;
        go();
        @(posedge clk);
        {load_a_wr, load_b_wr, clear_timeout_a} <= 3'h7;
        load_a_wdata <= 32'hABCD0003;
        load_b_wdata <= 16'h0004;
        go();
        expect_val(2, 32'h00040003);
        @(posedge clk);
        {ctl_wr, ctl_enable_a, ctl_enable_b} <= 3'h7;
        go();
        wait_on(5, 32'h1, 5000);
        wait_on(1, 32'h1, 5000);
        expect_val(1, 32'h1);
        expect_val(5, 32'h3);
        expect_val(0, 32'h3);
        ctl_wr <= 1'h1;
        {ctl_enable_a, ctl_enable_b} <= 2'h0;
        go();
        $display("split done");
        @(posedge clk);
        {match_wr, cfg_wr, mask_realtime_match} <= 3'h7;
        match_wdata <= 32'h2;
        cfg_wdata <= `GTM_CFG_32_RTC;
        go();
        expect_val(0, `GTM_RTC_START);
        expect_val(6, 32'h2);
        @(posedge clk);
        {ctl_wr, ctl_enable_a, ctl_realtime_en, ctl_stall_a, ctl_stall_b} <= 5'h1F;
        {debug_halt, osc_run} <= 2'h3;
        go();
        wait_on(4, 32'h1, 40000);
        expect_val(0, 32'h0);
        expect_val(4, 32'h3);
        clear_realtime_match <= 1'h1;
        go();
        expect_val(4, 32'h0);
        {debug_halt, osc_run} <= 2'h0;
        $display("clock done");
        #20;
        end_sim();
    end
endmodule
